// File: common/cdod_pkg.sv
// Constants and types shared by the clock divider and output distribution block
package cdod_pkg;

	// --------------------------------------------------------------
	// Sizes
	// --------------------------------------------------------------
	localparam int NUM_OUT = 8;
	localparam int NUM_DIV = 6;
	localparam int ADDR_W = 12;
	localparam int IDX_W = 10;
	localparam int NUM_PINS = 5;

	// --------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// --------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_MUTE_QUAL_A = 10'h014;
	localparam logic [IDX_W-1:0] IDX_MUTE_QUAL_B = 10'h015;
	localparam logic [IDX_W-1:0] IDX_MUTE_ON_INVALID = 10'h016;
	localparam logic [IDX_W-1:0] IDX_MARGIN_EN = 10'h018;
	localparam logic [IDX_W-1:0] IDX_POST_DIV = 10'h038;
	localparam logic [IDX_W-1:0] IDX_FRAC_MOD = 10'h042;
	localparam logic [IDX_W-1:0] IDX_STATUS = 10'h050;
	localparam logic [IDX_W-1:0] IDX_OUT_CTRL [NUM_OUT] = '{10'h01F, 10'h020, 10'h022,
		10'h023, 10'h025, 10'h027, 10'h029, 10'h02B};
	localparam logic [IDX_W-1:0] IDX_DIV [NUM_DIV] = '{10'h021, 10'h024, 10'h026,
		10'h028, 10'h02A, 10'h02C};
	// Divider that feeds each output
	localparam int OUT_DIV [NUM_OUT] = '{0, 0, 1, 1, 2, 3, 4, 5};

	// --------------------------------------------------------------
	// Field positions
	// --------------------------------------------------------------
	localparam int PDIV_LSB = 2;
	localparam int PDIV_MSB = 4;
	localparam int MUX_LSB = 6;
	localparam int MUX_MSB = 7;
	localparam int EN_MSB = 5;
	localparam int LEG_P_LSB = 0;
	localparam int LEG_N_LSB = 2;
	localparam int FMT_LSB = 4;
	localparam int MOD_MSB = 1;
	localparam int ST_GATE_LSB = 8;
	localparam int ST_MUTE_LSB = 16;

	// --------------------------------------------------------------
	// Codes and limits
	// --------------------------------------------------------------
	localparam logic [1:0] MUX_PRI = 2'h0;
	localparam logic [1:0] MUX_SEC = 2'h1;
	localparam logic [1:0] FMT_SINGLE = 2'h1;
	localparam logic [7:0] QUAL_ARMED = 8'hFF;
	localparam logic [7:0] MARGIN_MIN_M1 = 8'h08;
	localparam logic [3:0] PDIV_MIN = 4'h2;
	localparam logic [3:0] PDIV_MAX = 4'h8;

	// --------------------------------------------------------------
	// Reset values
	// --------------------------------------------------------------
	localparam logic [7:0] RST_OUT_CTRL = 8'h00;
	localparam logic [7:0] RST_DIV = 8'h03;
	localparam logic [7:0] RST_POST_DIV = 8'h08;
	localparam logic [7:0] RST_MISC = 8'h00;

	typedef enum logic [1:0] {LEG_OFF, LEG_INPHASE, LEG_COMPL, LEG_SPARE} cdod_leg_t;

endpackage

// File: core/cdod_dist.sv
// Post divider, output selectors, output dividers, gating and APB registers
// Operation
// - Post divider divides oscillator clock by 2 to 8 from field bits 4:2.
// - Outputs 4-7 each select primary, secondary or loop clock via bits 7:6.
// - A selected reference is passed at its own, undoubled frequency.
// - Six output dividers accept any divide value 1 through 256.
// - Outputs 0,1 share a divider, 2,3 share one, 4-7 have their own.
// - Glitch-free margining only above divide 8, enabled per divider bit.
// - Margined divide value changes never produce glitches or runt pulses.
// - Each output may be muted when its source turns invalid.
// - Source invalid: reference lost, or the loop reports unlock.
// - Writing zero to control bits 5:0 stops driving that output.
// - Single-ended legs each configurable complementary, in-phase or off.
// - Modulator order held in bits 1:0 of the fractional control register.
// - Output enable and mute change only while the output clock is low.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module cdod_dist (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cdod_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Reference and loop status pins
	input wire logic pri_ref,
	input wire logic sec_ref,
	input wire logic pri_los,
	input wire logic sec_los,
	input wire logic pll_unlock,
	// Clock outputs
	output logic [cdod_pkg::NUM_OUT-1:0] clk_p,
	output logic [cdod_pkg::NUM_OUT-1:0] clk_n,
	output logic [cdod_pkg::NUM_OUT-1:0] clk_p_oe,
	output logic [cdod_pkg::NUM_OUT-1:0] clk_n_oe,
	// Modulator order to the fractional circuitry
	output logic [1:0] mod_order
);
	import cdod_pkg::*;

	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------
	logic [7:0] out_ctrl [NUM_OUT];
	logic [7:0] div_val [NUM_DIV];
	logic [7:0] mute_qualifier_a;
	logic [7:0] mute_qualifier_b;
	logic [7:0] mute_on_invalid_register;
	logic [7:0] margining_enable_register;
	logic [7:0] post_divider_control;
	logic [7:0] fractional_modulator_control;

	logic [IDX_W-1:0] idx;
	logic aligned;
	logic wr_go;
	logic [NUM_PINS-1:0] pin_meta;
	logic [NUM_PINS-1:0] pin_sync;
	logic pri_s;
	logic sec_s;
	logic pri_los_s;
	logic sec_los_s;
	logic unlock_s;
	logic [2:0] pcnt;
	logic [2:0] next_pcnt;
	logic [3:0] pdiv_n;
	logic pll_lvl;
	logic [NUM_DIV-1:0] src;
	logic [NUM_DIV-1:0] divclk;
	logic [NUM_OUT-1:0] src_invalid;
	logic [NUM_OUT-1:0] mute_now;
	logic [NUM_OUT-1:0] gate;
	logic [NUM_OUT-1:0] mute_g;
	logic [NUM_OUT-1:0] oclk;
	logic armed;

	assign idx = paddr[ADDR_W-1:2];
	assign aligned = (paddr[1:0] == 2'h0);
	assign wr_go = psel && penable && pready && pwrite && mapped(idx) && aligned;

	function automatic logic mapped(input logic [IDX_W-1:0] a);
		logic hit;
		hit = (a == IDX_MUTE_QUAL_A) || (a == IDX_MUTE_QUAL_B) || (a == IDX_MUTE_ON_INVALID) ||
			(a == IDX_MARGIN_EN) || (a == IDX_POST_DIV) || (a == IDX_FRAC_MOD) ||
			(a == IDX_STATUS);
		for (int i = 0; i < NUM_OUT; i++) begin
			hit = hit || (a == IDX_OUT_CTRL[i]);
		end
		for (int k = 0; k < NUM_DIV; k++) begin
			hit = hit || (a == IDX_DIV[k]);
		end
		return hit;
	endfunction

	function automatic logic [31:0] read_reg(input logic [IDX_W-1:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		if (a == IDX_MUTE_QUAL_A) begin
			d[7:0] = mute_qualifier_a;
		end else if (a == IDX_MUTE_QUAL_B) begin
			d[7:0] = mute_qualifier_b;
		end else if (a == IDX_MUTE_ON_INVALID) begin
			d[7:0] = mute_on_invalid_register;
		end else if (a == IDX_MARGIN_EN) begin
			d[7:0] = margining_enable_register;
		end else if (a == IDX_POST_DIV) begin
			d[7:0] = post_divider_control;
		end else if (a == IDX_FRAC_MOD) begin
			d[7:0] = fractional_modulator_control;
		end else if (a == IDX_STATUS) begin
			d[2:0] = {unlock_s, sec_los_s, pri_los_s};
			d[ST_GATE_LSB +: NUM_OUT] = gate;
			d[ST_MUTE_LSB +: NUM_OUT] = mute_g;
		end
		for (int i = 0; i < NUM_OUT; i++) begin
			if (a == IDX_OUT_CTRL[i]) begin
				d[7:0] = out_ctrl[i];
			end
		end
		for (int k = 0; k < NUM_DIV; k++) begin
			if (a == IDX_DIV[k]) begin
				d[7:0] = div_val[k];
			end
		end
		return d;
	endfunction

	// --------------------------------------------------------------
	// APB slave: data prepared in setup, one access cycle, no waits
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			if (psel && !penable) begin
				pslverr <= !(mapped(idx) && aligned);
				prdata <= (!pwrite && aligned) ? read_reg(idx) : 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mute_qualifier_a <= RST_MISC;
			mute_qualifier_b <= RST_MISC;
			mute_on_invalid_register <= RST_MISC;
			margining_enable_register <= RST_MISC;
			post_divider_control <= RST_POST_DIV;
			fractional_modulator_control <= RST_MISC;
			for (int i = 0; i < NUM_OUT; i++) begin
				out_ctrl[i] <= RST_OUT_CTRL;
			end
			for (int k = 0; k < NUM_DIV; k++) begin
				div_val[k] <= RST_DIV;
			end
		end else if (wr_go) begin
			if (idx == IDX_MUTE_QUAL_A) begin
				mute_qualifier_a <= pwdata[7:0];
			end else if (idx == IDX_MUTE_QUAL_B) begin
				mute_qualifier_b <= pwdata[7:0];
			end else if (idx == IDX_MUTE_ON_INVALID) begin
				mute_on_invalid_register <= pwdata[7:0];
			end else if (idx == IDX_MARGIN_EN) begin
				margining_enable_register <= pwdata[7:0];
			end else if (idx == IDX_POST_DIV) begin
				post_divider_control <= pwdata[7:0];
			end else if (idx == IDX_FRAC_MOD) begin
				fractional_modulator_control <= pwdata[7:0];
			end
			for (int i = 0; i < NUM_OUT; i++) begin
				if (idx == IDX_OUT_CTRL[i]) begin
					out_ctrl[i] <= pwdata[7:0];
				end
			end
			for (int k = 0; k < NUM_DIV; k++) begin
				if (idx == IDX_DIV[k]) begin
					div_val[k] <= pwdata[7:0];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mod_order <= 2'h0;
		end else begin
			mod_order <= fractional_modulator_control[MOD_MSB:0];
		end
	end

	// --------------------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= {pll_unlock, sec_los, pri_los, sec_ref, pri_ref};
			pin_sync <= pin_meta;
		end
	end
	assign {unlock_s, sec_los_s, pri_los_s, sec_s, pri_s} = pin_sync;

	// --------------------------------------------------------------
	// Post divider; pclk stands in for the oscillator clock
	// --------------------------------------------------------------
	always_comb begin
		// Spare code 7 divides by the maximum
		pdiv_n = {1'b0, post_divider_control[PDIV_MSB:PDIV_LSB]} + PDIV_MIN;
		if (pdiv_n > PDIV_MAX) begin
			pdiv_n = PDIV_MAX;
		end
		next_pcnt = (pcnt >= 3'(pdiv_n - 4'h1)) ? 3'h0 : pcnt + 3'h1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Last count of a period, so the first rise after reset opens a full period
			pcnt <= 3'({1'b0, RST_POST_DIV[PDIV_MSB:PDIV_LSB]} + PDIV_MIN - 4'h1);
			pll_lvl <= 1'b0;
		end else begin
			pcnt <= next_pcnt;
			pll_lvl <= ({1'b0, next_pcnt} < {1'b0, pdiv_n[3:1]});
		end
	end

	// --------------------------------------------------------------
	// Source selection, dividers and output stage
	// --------------------------------------------------------------
	assign armed = (mute_qualifier_a == QUAL_ARMED) && (mute_qualifier_b == QUAL_ARMED);

	function automatic logic pick(input logic [1:0] sel, input logic p, input logic s,
		input logic l);
		// References pass as received, never doubled
		return (sel == MUX_PRI) ? p : (sel == MUX_SEC) ? s : l;
	endfunction

	function automatic logic leg_on(input logic [1:0] m);
		return (m == LEG_INPHASE) || (m == LEG_COMPL) || (m == LEG_SPARE);
	endfunction

	function automatic logic leg_val(input logic [1:0] m, input logic c);
		return (m == LEG_COMPL) ? !c : (m == LEG_OFF) ? 1'b0 : c;
	endfunction

	genvar gk;
	generate
		for (gk = 0; gk < NUM_DIV; gk++) begin : g_div
			if (gk < 2) begin : g_pll
				assign src[gk] = pll_lvl;
			end else begin : g_mux
				assign src[gk] = pick(out_ctrl[gk + 2][MUX_MSB:MUX_LSB], pri_s, sec_s,
					pll_lvl);
			end
			cdod_out_div u_div (
				.pclk(pclk),
				.presetn(presetn),
				.src(src[gk]),
				.div_m1(div_val[gk]),
				.margin_en(margining_enable_register[gk]),
				.clk_out(divclk[gk])
			);
		end
	endgenerate

	genvar gi;
	generate
		for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
			if (gi < 4) begin : g_lp
				assign src_invalid[gi] = unlock_s;
			end else begin : g_sel
				assign src_invalid[gi] = pick(out_ctrl[gi][MUX_MSB:MUX_LSB], pri_los_s,
					sec_los_s, unlock_s);
			end
			assign mute_now[gi] = mute_on_invalid_register[gi] && src_invalid[gi] && armed;
			assign oclk[gi] = divclk[OUT_DIV[gi]] && !mute_g[gi];

			// Gating moves only while the clock is low, so no runt pulse escapes
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					gate[gi] <= 1'b0;
					mute_g[gi] <= 1'b0;
				end else if (!divclk[OUT_DIV[gi]]) begin
					gate[gi] <= (out_ctrl[gi][EN_MSB:0] != 6'h00);
					mute_g[gi] <= mute_now[gi];
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					clk_p[gi] <= 1'b0;
					clk_n[gi] <= 1'b0;
					clk_p_oe[gi] <= 1'b0;
					clk_n_oe[gi] <= 1'b0;
				end else if (!gate[gi]) begin
					clk_p[gi] <= 1'b0;
					clk_n[gi] <= 1'b0;
					clk_p_oe[gi] <= 1'b0;
					clk_n_oe[gi] <= 1'b0;
				end else if (out_ctrl[gi][FMT_LSB +: 2] == FMT_SINGLE) begin
					clk_p[gi] <= leg_val(out_ctrl[gi][LEG_P_LSB +: 2], oclk[gi]);
					clk_n[gi] <= leg_val(out_ctrl[gi][LEG_N_LSB +: 2], oclk[gi]);
					clk_p_oe[gi] <= leg_on(out_ctrl[gi][LEG_P_LSB +: 2]);
					clk_n_oe[gi] <= leg_on(out_ctrl[gi][LEG_N_LSB +: 2]);
				end else begin
					clk_p[gi] <= oclk[gi];
					clk_n[gi] <= !oclk[gi];
					clk_p_oe[gi] <= 1'b1;
					clk_n_oe[gi] <= 1'b1;
				end
			end

			disable_off_a: assert property (@(posedge pclk) disable iff (!presetn)
				!gate[gi] |=> !clk_p_oe[gi] && !clk_n_oe[gi] && !clk_p[gi])
				else $error("disabled output still driven");
			gate_low_a: assert property (@(posedge pclk) disable iff (!presetn)
				$changed(gate[gi]) || $changed(mute_g[gi]) |-> !$past(divclk[OUT_DIV[gi]]))
				else $error("output gating changed while clock high");
			mute_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
				gate[gi] && mute_g[gi] && (out_ctrl[gi][FMT_LSB +: 2] != FMT_SINGLE)
				|=> !clk_p[gi] && clk_n[gi])
				else $error("muted output still toggling");
			leg_off_a: assert property (@(posedge pclk) disable iff (!presetn)
				gate[gi] && (out_ctrl[gi][FMT_LSB +: 2] == FMT_SINGLE) &&
				(out_ctrl[gi][LEG_P_LSB +: 2] == LEG_OFF) |=> !clk_p_oe[gi])
				else $error("switched-off leg is driven");
		end
	endgenerate

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	post_div_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(pll_lvl) && $stable(post_divider_control) &&
		($past(post_divider_control, 2) == post_divider_control)
		|-> $past(pcnt) == 3'(pdiv_n - 4'h1))
		else $error("post divider period wrong");
	invalid_mute_a: assert property (@(posedge pclk) disable iff (!presetn)
		unlock_s && armed && mute_on_invalid_register[0] && !divclk[0] |=> mute_g[0])
		else $error("unlock did not request muting");
	sel_pri_a: assert property (@(posedge pclk) disable iff (!presetn)
		out_ctrl[4][MUX_MSB:MUX_LSB] == MUX_PRI |-> src[2] == pri_s)
		else $error("output four selector ignored primary choice");
	mod_order_a: assert property (@(posedge pclk) disable iff (!presetn)
		##1 mod_order == $past(fractional_modulator_control[MOD_MSB:0]))
		else $error("modulator order not forwarded");
	apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready ##1 !pready)
		else $error("pready not a single access cycle");
	apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !mapped(idx) |=> pslverr)
		else $error("unmapped access not flagged");
	mute_cov: cover property (@(posedge pclk) disable iff (!presetn) $rose(mute_g[4]));
	single_cov: cover property (@(posedge pclk) disable iff (!presetn)
		gate[4] && (out_ctrl[4][FMT_LSB +: 2] == FMT_SINGLE) ##1 $rose(clk_p[4]));
	ref_cov: cover property (@(posedge pclk) disable iff (!presetn)
		(out_ctrl[6][MUX_MSB:MUX_LSB] == MUX_SEC) && gate[6] ##1 $rose(clk_p[6]));

endmodule

// File: core/cdod_out_div.sv
// One output divider with period-boundary reload of its divide value
`timescale 1ns/100ps
module cdod_out_div (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Source and settings
	input wire logic src,
	input wire logic [7:0] div_m1,
	input wire logic margin_en,
	// Divided clock
	output logic clk_out
);
	import cdod_pkg::*;

	logic src_d;
	logic [7:0] cur;
	logic [8:0] cnt;
	logic [7:0] next_cur;
	logic [8:0] next_cnt;
	logic edge_ev;
	logic last;
	logic glitchless;

	// Both source edges are counted, so any divide value keeps a 50 % duty
	assign edge_ev = src ^ src_d;
	assign last = (cnt == {cur, 1'b1});
	assign glitchless = margin_en && (cur >= MARGIN_MIN_M1) && (div_m1 >= MARGIN_MIN_M1);

	always_comb begin
		next_cur = cur;
		next_cnt = cnt;
		if ((div_m1 != cur) && !glitchless) begin
			// Without margining the new value restarts the count at once
			next_cur = div_m1;
			next_cnt = 9'h000;
		end else if (edge_ev) begin
			if (last) begin
				next_cnt = 9'h000;
				next_cur = div_m1;
			end else begin
				next_cnt = cnt + 9'h001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_d <= 1'b0;
			cur <= RST_DIV;
			cnt <= 9'h000;
			clk_out <= 1'b0;
		end else begin
			src_d <= src;
			cur <= next_cur;
			cnt <= next_cnt;
			clk_out <= (next_cnt <= {1'b0, next_cur});
		end
	end

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	reload_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
		glitchless && (div_m1 != cur) && !(edge_ev && last) |=> $stable(cur))
		else $error("divide value reloaded inside a margined period");
	wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
		edge_ev && last |=> (cnt == 9'h000) && clk_out)
		else $error("divider did not wrap at the end of its period");
	margin_cov: cover property (@(posedge pclk) disable iff (!presetn)
		glitchless && (div_m1 != cur) ##[1:600] $changed(cur));

endmodule

// File: testbench/cdod_dist_bench.sv
// Self-checking bench for the clock divider and output distribution block
`timescale 1ns/100ps
module cdod_dist_bench;
	import cdod_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pri_ref = 1'b0;
	logic sec_ref = 1'b0;
	logic pri_los = 1'b0;
	logic sec_los = 1'b0;
	logic pll_unlock = 1'b0;
	logic [NUM_OUT-1:0] clk_p, clk_n, clk_p_oe, clk_n_oe;
	logic [1:0] mod_order;
	logic meas_clr = 1'b0;
	logic [15:0] period [NUM_OUT];
	logic [15:0] min_high [NUM_OUT];
	logic [31:0] rdat;
	logic rerr;
	int err_count = 0;
	int checked = 0;
	int cycles = 0;
	int ref_cnt = 0;

	always #12.5 pclk = ~pclk;

	cdod_dist dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pri_ref(pri_ref), .sec_ref(sec_ref), .pri_los(pri_los),
		.sec_los(sec_los), .pll_unlock(pll_unlock), .clk_p(clk_p), .clk_n(clk_n),
		.clk_p_oe(clk_p_oe), .clk_n_oe(clk_n_oe), .mod_order(mod_order));

	cdod_rx_model rx_u (.pclk(pclk), .presetn(presetn), .clk_p(clk_p), .clk_p_oe(clk_p_oe),
		.meas_clr(meas_clr), .period(period), .min_high(min_high));

	// ----------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------
	// References: primary period 10 cycles, secondary period 6 cycles
	always @(posedge pclk) begin
		ref_cnt <= (ref_cnt == 29) ? 0 : ref_cnt + 1;
		pri_ref <= (ref_cnt % 10) < 5;
		sec_ref <= (ref_cnt % 6) < 3;
	end

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			err_count++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// An idle cycle follows every transfer, so no signal is assigned twice at one edge
	task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d);
	endtask

	task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h00000000);
		chk(rdat, exp);
	endtask

	task automatic meas(input int n);
		meas_clr <= 1'b1;
		@(posedge pclk);
		meas_clr <= 1'b0;
		repeat (n) @(posedge pclk);
	endtask

	// ----------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------
	task automatic t_reset();
		rd_chk(IDX_OUT_CTRL[0], 32'h00000000);
		rd_chk(IDX_DIV[0], 32'h00000003);
		rd_chk(IDX_POST_DIV, 32'h00000008);
		chk({16'h0000, clk_p_oe, clk_n_oe}, 32'h00000000);
		apb(1'b0, 10'h001, 32'h00000000);
		chk({31'h00000000, rerr}, 32'h00000001);
	endtask

	task automatic t_mod();
		for (int m = 3; m >= 0; m--) begin
			wr(IDX_FRAC_MOD, 32'(m));
			@(posedge pclk);
			chk({30'h00000000, mod_order}, 32'(m));
			rd_chk(IDX_FRAC_MOD, 32'(m));
		end
	endtask

	task automatic t_post();
		wr(IDX_DIV[2], 32'h00000000);
		wr(IDX_OUT_CTRL[4], 32'h00000081);
		for (int f = 0; f < 8; f++) begin
			wr(IDX_POST_DIV, 32'(f << 2));
			meas(40);
			chk({16'h0000, period[4]}, (f > 5) ? 32'h00000008 : 32'(f + 2));
		end
	endtask

	task automatic t_div();
		wr(IDX_POST_DIV, 32'h00000000);
		for (int i = 0; i < 3; i++) wr(IDX_OUT_CTRL[i], 32'h00000001);
		wr(IDX_DIV[0], 32'h00000002);
		wr(IDX_DIV[1], 32'h00000004);
		wr(IDX_DIV[2], 32'h000000FF);
		meas(1600);
		chk({period[0], period[1]}, 32'h00060006);
		chk({16'h0000, period[2]}, 32'h0000000A);
		chk({16'h0000, period[4]}, 32'h00000200);
		wr(IDX_DIV[2], 32'h00000000);
	endtask

	task automatic t_ref();
		wr(IDX_OUT_CTRL[5], 32'h00000001);
		wr(IDX_OUT_CTRL[6], 32'h00000041);
		wr(IDX_DIV[3], 32'h00000000);
		wr(IDX_DIV[4], 32'h00000000);
		meas(60);
		chk({period[5], period[6]}, 32'h000A0006);
	endtask

	task automatic t_mute();
		wr(IDX_MUTE_ON_INVALID, 32'h00000031);
		wr(IDX_MUTE_QUAL_A, 32'h000000FF);
		wr(IDX_MUTE_QUAL_B, 32'h0000007F);
		pll_unlock <= 1'b1;
		meas(30);
		chk({16'h0000, period[4]}, 32'h00000002);
		wr(IDX_MUTE_QUAL_B, 32'h000000FF);
		meas(30);
		chk({14'h0000, clk_p[4], clk_n[4], period[4]}, 32'h00010000);
		pll_unlock <= 1'b0;
		pri_los <= 1'b1;
		meas(40);
		chk({period[4], period[5]}, 32'h00020000);
		rd_chk(IDX_STATUS, 32'h00207701);
		pri_los <= 1'b0;
	endtask

	task automatic se_step(input logic [7:0] ctrl, input logic [1:0] oe, input logic inv);
		wr(IDX_OUT_CTRL[4], {24'h000000, ctrl});
		repeat (8) @(posedge pclk);
		repeat (4) begin
			@(posedge pclk);
			chk({30'h00000000, clk_p_oe[4], clk_n_oe[4]}, {30'h00000000, oe});
			if (oe == 2'h3) chk({31'h00000000, clk_p[4] ^ clk_n[4]}, {31'h00000000, inv});
		end
	endtask

	task automatic t_se();
		se_step(8'h99, 2'h3, 1'b1);
		se_step(8'h91, 2'h2, 1'b0);
		se_step(8'h95, 2'h3, 1'b0);
		se_step(8'h9F, 2'h3, 1'b0);
		se_step(8'h94, 2'h1, 1'b0);
		se_step(8'h80, 2'h0, 1'b0);
	endtask

	// Rewrites land at varying phases; the P leg runs inverted, so a cut low
	// phase of the divided clock shows as a high phase under 10
	task automatic t_margin();
		wr(IDX_MARGIN_EN, 32'h00000004);
		wr(IDX_DIV[2], 32'h00000009);
		wr(IDX_OUT_CTRL[4], 32'h00000092);
		repeat (40) @(posedge pclk);
		meas(60);
		for (int k = 0; k < 6; k++) begin
			wr(IDX_DIV[2], 32'h0000000B);
			repeat (k + 5) @(posedge pclk);
			wr(IDX_DIV[2], 32'h00000009);
			repeat (2 * k + 3) @(posedge pclk);
		end
		repeat (60) @(posedge pclk);
		chk({16'h0000, min_high[4]}, 32'h0000000A);
	endtask

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_mod();
		t_post();
		t_div();
		t_ref();
		t_mute();
		t_se();
		t_margin();
		end_sim();
	end
endmodule

// File: testbench/cdod_rx_model.sv
// Receiver model that measures period and shortest high phase of each output
`timescale 1ns/100ps
module cdod_rx_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Observed legs
	input wire logic [cdod_pkg::NUM_OUT-1:0] clk_p,
	input wire logic [cdod_pkg::NUM_OUT-1:0] clk_p_oe,
	// Restart of the measurement
	input wire logic meas_clr,
	// Results
	output logic [15:0] period [cdod_pkg::NUM_OUT],
	output logic [15:0] min_high [cdod_pkg::NUM_OUT]
);
	import cdod_pkg::*;
	logic [15:0] cnt [NUM_OUT];
	logic [15:0] hi [NUM_OUT];
	logic [NUM_OUT-1:0] last;
	logic [NUM_OUT-1:0] seen;
	logic [NUM_OUT-1:0] lvl;

	// An undriven leg reads low, as at a terminated receiver
	assign lvl = clk_p & clk_p_oe;

	// ----------------------------------------------------------
	// Measurement
	// ----------------------------------------------------------
	// The first high phase after a restart may be partial, so it is not counted
	// Reset is taken on the clock; the bench holds it for many cycles
	always_ff @(posedge pclk) begin
		for (int i = 0; i < NUM_OUT; i++) begin
			last[i] <= lvl[i];
			if (!presetn || meas_clr) begin
				cnt[i] <= 16'h0000;
				hi[i] <= 16'h0000;
				period[i] <= 16'h0000;
				min_high[i] <= 16'hFFFF;
				seen[i] <= 1'b0;
			end else begin
				cnt[i] <= (lvl[i] && !last[i]) ? 16'h0001 : cnt[i] + 16'h0001;
				hi[i] <= lvl[i] ? hi[i] + 16'h0001 : 16'h0000;
				if (lvl[i] && !last[i]) begin
					seen[i] <= 1'b1;
					if (seen[i]) begin
						period[i] <= cnt[i];
					end
				end
				if (!lvl[i] && last[i] && seen[i] && hi[i] < min_high[i]) begin
					min_high[i] <= hi[i];
				end
			end
		end
	end
endmodule
